// [hw/net_boot_pkg.sv]
// Constants shared by the network boot client sequencer
package net_boot_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int NS_PER_MS = 1000000;
  localparam int CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam logic [15:0] DEF_TIMEOUT_MS = 16'h0BB8;
  localparam logic [4:0] RETRY_LIMIT = 5'h10;
  localparam logic [47:0] BCAST_ADDR = 48'hFFFF_FFFF_FFFF;
  localparam int ID_W = 128;
  localparam int SESSION_W = 96;
  localparam int SERIAL_W = ID_W - SESSION_W;
  localparam logic [31:0] LFSR_SEED = 32'hACE1_2468;
  // Request codes, shared by requests and replies
  localparam logic [7:0] CODE_DOWNLOAD = 8'h00;
  localparam logic [7:0] CODE_UPLOAD = 8'h01;
  localparam logic [7:0] CODE_RUN = 8'h02;
  localparam logic [7:0] CODE_CONFIGURE = 8'h03;
  localparam logic [7:0] CODE_DISCOVERY = 8'h04;
  localparam logic [7:0] CODE_CLAIM = 8'h05;
  // Error codes shown on the status indicator
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_DISCOVERY = 8'h01;
  localparam logic [7:0] ERR_CLAIM = 8'h02;
  localparam logic [7:0] ERR_ORDER = 8'h03;
endpackage

// [hw/boot_ms_timer.sv]
// Millisecond tick and restartable timeout counter
module boot_ms_timer #(
  parameter int CYC_PER_MS = net_boot_pkg::CYC_PER_MS
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_restart,
  input wire logic [15:0] i_limit_ms,
  output logic o_expired
);
  typedef struct packed {
    logic [17:0] div;
    logic [15:0] ms;
    logic armed;
    logic expired;
  } timer_state_type;

  timer_state_type t_ff;
  timer_state_type nxt_t;

  always_comb begin
    nxt_t = t_ff;
    nxt_t.expired = 1'b0;
    if (i_restart) begin
      nxt_t.div = '0;
      nxt_t.ms = '0;
      nxt_t.armed = 1'b1;
    end else if (t_ff.div == 18'(CYC_PER_MS - 1)) begin
      nxt_t.div = '0;
      if (t_ff.armed) begin
        nxt_t.ms = t_ff.ms + 16'h0001;
        // Expire once the configured interval has elapsed
        if (t_ff.ms + 16'h0001 >= i_limit_ms) begin
          nxt_t.expired = 1'b1;
          nxt_t.armed = 1'b0;
        end
      end
    end else begin
      nxt_t.div = t_ff.div + 18'h00001;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      t_ff <= '0;
    end else begin
      t_ff <= nxt_t;
    end
  end

  assign o_expired = t_ff.expired;
endmodule

// [hw/net_boot_client_sequencer.sv]
// Network boot client: discovery, claim, order handling and retries
// Behaviour
// - After server known, drop other sources
// - Drop message types unexpected in state
// - Waiting states time out, default 3000 ms
// - Discovery counter cleared at kickoff, counts sends
// - Claim counter cleared on discovery reply
// - Discovery timeout resends; fail after 16
// - Failure shows error code until reset
// - Host-started failure writes completion code
// - Claim timeout resends; after 16 rediscover
// - Order timeout rediscovers; abort after 16
// - Request IDs unique, with random part
// - Ignore orders with wrong session ID
// - Replies copy whole request ID field
// - At most one order outstanding
// - Accept only first discovery reply
// - Discovery broadcast, rest to server
// - Request codes 0 to 5
module net_boot_client_sequencer #(
  parameter int CYC_PER_MS = net_boot_pkg::CYC_PER_MS
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_boot_kickoff,
  input wire logic i_host_started,
  input wire logic [47:0] i_own_addr,
  input wire logic i_rx_valid,
  input wire logic i_rx_is_reply,
  input wire logic [7:0] i_rx_code,
  input wire logic [47:0] i_rx_src,
  input wire logic [127:0] i_rx_msg_id,
  input wire logic [47:0] i_rx_srv_addr,
  input wire logic [15:0] i_rx_timeout_ms,
  input wire logic [95:0] i_rx_session,
  input wire logic i_tx_ready,
  input wire logic i_order_done,
  input wire logic [7:0] i_order_result,
  output logic o_tx_valid,
  output logic o_tx_is_reply,
  output logic [7:0] o_tx_code,
  output logic [7:0] o_tx_reply_code,
  output logic [47:0] o_tx_dest,
  output logic [127:0] o_tx_msg_id,
  output logic o_order_valid,
  output logic [7:0] o_order_code,
  output logic o_running,
  output logic o_failed,
  output logic [7:0] o_status_code,
  output logic o_host_cc_we,
  output logic [7:0] o_host_cc_code
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_DISC_WAIT, ST_CLAIM_WAIT, ST_ORDER_WAIT, ST_ORDER_BUSY,
    ST_RUN, ST_FAILED
  } boot_state_type;

  typedef struct packed {
    boot_state_type st;
    logic [4:0] disc_cnt;
    logic [4:0] claim_cnt;
    logic host_flag;
    logic [47:0] srv_addr;
    logic [95:0] session;
    logic [127:0] cur_id;
    logic [127:0] order_id;
    logic [15:0] tmo_ms;
    logic [31:0] lfsr;
    logic [31:0] seq;
    logic restart;
    logic tx_valid;
    logic tx_is_reply;
    logic [7:0] tx_code;
    logic [7:0] tx_reply_code;
    logic [47:0] tx_dest;
    logic [127:0] tx_id;
    logic order_valid;
    logic [7:0] order_code;
    logic [7:0] status;
    logic host_cc_we;
    logic running;
    logic failed;
  } client_state_type;

  client_state_type s_ff;
  client_state_type nxt_s;
  logic expired;
  logic tmo;
  logic from_srv;
  logic send_disc;
  logic send_claim;
  logic fail;
  logic [7:0] fail_code;
  logic [127:0] new_id;

  boot_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_restart(s_ff.restart),
    .i_limit_ms(s_ff.tmo_ms),
    .o_expired(expired)
  );

  // A stale expiry from the previous wait is ignored while restarting
  assign tmo = expired && !s_ff.restart;
  assign from_srv = i_rx_src == s_ff.srv_addr;
  // Own address, sequence and random part keep request IDs apart
  assign new_id = {i_own_addr, 16'h0000, s_ff.lfsr, s_ff.seq};

  always_comb begin
    nxt_s = s_ff;
    send_disc = 1'b0;
    send_claim = 1'b0;
    fail = 1'b0;
    fail_code = net_boot_pkg::ERR_NONE;
    nxt_s.lfsr = {s_ff.lfsr[30:0],
                  s_ff.lfsr[31] ^ s_ff.lfsr[21] ^ s_ff.lfsr[1] ^ s_ff.lfsr[0]};
    nxt_s.tx_valid = s_ff.tx_valid && !i_tx_ready;
    nxt_s.order_valid = 1'b0;
    nxt_s.host_cc_we = 1'b0;
    nxt_s.restart = 1'b0;
    case (s_ff.st)
      ST_IDLE: begin
        if (i_boot_kickoff) begin
          nxt_s.disc_cnt = '0;
          nxt_s.claim_cnt = '0;
          nxt_s.host_flag = i_host_started;
          send_disc = 1'b1;
        end
      end
      ST_DISC_WAIT: begin
        // Only the first matching discovery reply is taken
        if (i_rx_valid && i_rx_is_reply &&
            i_rx_code == net_boot_pkg::CODE_DISCOVERY &&
            i_rx_msg_id == s_ff.cur_id) begin
          nxt_s.srv_addr = i_rx_srv_addr;
          nxt_s.claim_cnt = '0;
          if (i_rx_timeout_ms != 16'h0000) begin
            nxt_s.tmo_ms = i_rx_timeout_ms;
          end
          send_claim = 1'b1;
        end else if (tmo) begin
          if (s_ff.disc_cnt >= net_boot_pkg::RETRY_LIMIT) begin
            fail = 1'b1;
            fail_code = net_boot_pkg::ERR_DISCOVERY;
          end else begin
            send_disc = 1'b1;
          end
        end
      end
      ST_CLAIM_WAIT: begin
        if (i_rx_valid && i_rx_is_reply && from_srv &&
            i_rx_code == net_boot_pkg::CODE_CLAIM &&
            i_rx_msg_id == s_ff.cur_id) begin
          nxt_s.session = i_rx_session;
          if (i_rx_timeout_ms != 16'h0000) begin
            nxt_s.tmo_ms = i_rx_timeout_ms;
          end
          nxt_s.st = ST_ORDER_WAIT;
          nxt_s.restart = 1'b1;
        end else if (tmo) begin
          if (s_ff.claim_cnt < net_boot_pkg::RETRY_LIMIT) begin
            send_claim = 1'b1;
          end else if (s_ff.disc_cnt < net_boot_pkg::RETRY_LIMIT) begin
            send_disc = 1'b1;
          end else begin
            fail = 1'b1;
            fail_code = net_boot_pkg::ERR_CLAIM;
          end
        end
      end
      ST_ORDER_WAIT: begin
        // Session must match; serial bytes are only kept for the echo
        if (i_rx_valid && !i_rx_is_reply && from_srv &&
            i_rx_code <= net_boot_pkg::CODE_CONFIGURE &&
            i_rx_msg_id[net_boot_pkg::ID_W-1:net_boot_pkg::SERIAL_W] ==
            s_ff.session) begin
          nxt_s.order_id = i_rx_msg_id;
          nxt_s.order_code = i_rx_code;
          nxt_s.order_valid = 1'b1;
          nxt_s.st = ST_ORDER_BUSY;
        end else if (tmo) begin
          if (s_ff.disc_cnt >= net_boot_pkg::RETRY_LIMIT) begin
            fail = 1'b1;
            fail_code = net_boot_pkg::ERR_ORDER;
          end else begin
            send_disc = 1'b1;
          end
        end
      end
      ST_ORDER_BUSY: begin
        // Single order buffer: new orders are dropped here
        if (i_order_done) begin
          nxt_s.tx_valid = 1'b1;
          nxt_s.tx_is_reply = 1'b1;
          nxt_s.tx_code = s_ff.order_code;
          nxt_s.tx_reply_code = i_order_result;
          nxt_s.tx_dest = s_ff.srv_addr;
          nxt_s.tx_id = s_ff.order_id;
          if (s_ff.order_code == net_boot_pkg::CODE_RUN) begin
            nxt_s.st = ST_RUN;
            nxt_s.running = 1'b1;
          end else begin
            nxt_s.st = ST_ORDER_WAIT;
            nxt_s.restart = 1'b1;
          end
        end
      end
      ST_RUN: begin
      end
      ST_FAILED: begin
      end
      default: begin
        nxt_s.st = ST_IDLE;
      end
    endcase
    if (send_disc) begin
      nxt_s.st = ST_DISC_WAIT;
      nxt_s.tx_dest = net_boot_pkg::BCAST_ADDR;
      nxt_s.tx_code = net_boot_pkg::CODE_DISCOVERY;
      if (s_ff.st != ST_IDLE) begin
        nxt_s.disc_cnt = s_ff.disc_cnt + 5'h01;
      end else begin
        nxt_s.disc_cnt = 5'h01;
      end
    end
    if (send_claim) begin
      nxt_s.st = ST_CLAIM_WAIT;
      nxt_s.tx_dest = (s_ff.st == ST_DISC_WAIT) ? i_rx_srv_addr
                                                : s_ff.srv_addr;
      nxt_s.tx_code = net_boot_pkg::CODE_CLAIM;
      nxt_s.claim_cnt = (s_ff.st == ST_DISC_WAIT) ? 5'h01
                                                  : s_ff.claim_cnt + 5'h01;
    end
    if (send_disc || send_claim) begin
      nxt_s.tx_valid = 1'b1;
      nxt_s.tx_is_reply = 1'b0;
      nxt_s.tx_reply_code = 8'h00;
      nxt_s.tx_id = new_id;
      nxt_s.cur_id = new_id;
      nxt_s.seq = s_ff.seq + 32'h0000_0001;
      nxt_s.restart = 1'b1;
    end
    if (fail) begin
      nxt_s.st = ST_FAILED;
      nxt_s.failed = 1'b1;
      nxt_s.status = fail_code;
      nxt_s.host_cc_we = s_ff.host_flag;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      s_ff <= '0;
      s_ff.st <= ST_IDLE;
      s_ff.tmo_ms <= net_boot_pkg::DEF_TIMEOUT_MS;
      s_ff.lfsr <= net_boot_pkg::LFSR_SEED;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_tx_valid = s_ff.tx_valid;
  assign o_tx_is_reply = s_ff.tx_is_reply;
  assign o_tx_code = s_ff.tx_code;
  assign o_tx_reply_code = s_ff.tx_reply_code;
  assign o_tx_dest = s_ff.tx_dest;
  assign o_tx_msg_id = s_ff.tx_id;
  assign o_order_valid = s_ff.order_valid;
  assign o_order_code = s_ff.order_code;
  assign o_running = s_ff.running;
  assign o_failed = s_ff.failed;
  assign o_status_code = s_ff.status;
  assign o_host_cc_we = s_ff.host_cc_we;
  assign o_host_cc_code = s_ff.status;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  disc_to_bcast_a: assert property (
    o_tx_valid && o_tx_code == net_boot_pkg::CODE_DISCOVERY &&
    !o_tx_is_reply |-> o_tx_dest == net_boot_pkg::BCAST_ADDR)
    else $error("discovery request not broadcast");
  kickoff_count_a: assert property (
    s_ff.st == ST_IDLE && i_boot_kickoff |=>
    s_ff.disc_cnt == 5'h01 && o_tx_valid && s_ff.st == ST_DISC_WAIT)
    else $error("kickoff did not start discovery");
  disc_retry_a: assert property (
    s_ff.st == ST_DISC_WAIT && tmo && !i_rx_valid &&
    s_ff.disc_cnt < 5'h10 |=>
    o_tx_valid && s_ff.disc_cnt == $past(s_ff.disc_cnt) + 5'h01)
    else $error("discovery retry missing");
  disc_limit_a: assert property (
    s_ff.disc_cnt <= 5'h10 && s_ff.claim_cnt <= 5'h10)
    else $error("retry counter over limit");
  fail_hold_a: assert property (
    o_failed |=> o_failed && $stable(o_status_code) &&
    o_status_code != net_boot_pkg::ERR_NONE)
    else $error("failure state not held");
  host_code_a: assert property (
    o_host_cc_we |-> o_failed && s_ff.host_flag &&
    !$past(o_failed))
    else $error("completion code write out of place");
  claim_clear_a: assert property (
    $rose(s_ff.st == ST_CLAIM_WAIT) |->
    s_ff.claim_cnt == 5'h01)
    else $error("claim counter not restarted");
  order_session_a: assert property (
    o_order_valid |-> $past(i_rx_msg_id[127:32]) == s_ff.session &&
    $past(i_rx_src) == s_ff.srv_addr)
    else $error("order accepted with wrong session");
  reply_echo_a: assert property (
    $rose(o_tx_valid && o_tx_is_reply) |->
    o_tx_msg_id == s_ff.order_id && o_tx_dest == s_ff.srv_addr)
    else $error("reply id not echoed");
  order_tmo_a: assert property (
    s_ff.st == ST_ORDER_WAIT && tmo && !i_rx_valid |=>
    (s_ff.st == ST_DISC_WAIT) || o_failed)
    else $error("order timeout not handled");

  boot_run_c: cover property (o_running);
  boot_fail_c: cover property ($rose(o_failed));
  claim_retry_c: cover property (
    s_ff.st == ST_CLAIM_WAIT && tmo ##1 s_ff.st == ST_CLAIM_WAIT);
  order_done_c: cover property (o_order_valid ##[1:20] i_order_done);
endmodule

// [dv/boot_server_model.sv]
// Boot server model: answers the client and logs what it sends
module boot_server_model (
  input wire logic i_sys_clk,
  input wire logic i_tx_valid,
  input wire logic i_tx_ready,
  input wire logic [7:0] i_tx_code,
  input wire logic [47:0] i_tx_dest,
  input wire logic [127:0] i_tx_msg_id,
  output logic o_rx_valid,
  output logic o_rx_is_reply,
  output logic [7:0] o_rx_code,
  output logic [47:0] o_rx_src,
  output logic [127:0] o_rx_msg_id,
  output logic [47:0] o_rx_srv_addr,
  output logic [15:0] o_rx_timeout_ms,
  output logic [95:0] o_rx_session
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [47:0] SRV = 48'h0200_0000_0A01;
  localparam logic [95:0] SESSION = 96'h1234_5678_9ABC_DEF0_0F1E_2D3C;
  logic [7:0] q_code[$];
  logic [47:0] q_dest[$];
  logic [127:0] q_id[$];
  logic [127:0] last_id = '0;
  initial begin
    o_rx_valid = 1'b0;
    {o_rx_is_reply, o_rx_code, o_rx_src, o_rx_msg_id} = '0;
    {o_rx_srv_addr, o_rx_timeout_ms, o_rx_session} = '0;
  end
  always @(posedge i_sys_clk) begin
    if (i_tx_valid && i_tx_ready) begin
      q_code.push_back(i_tx_code);
      q_dest.push_back(i_tx_dest);
      q_id.push_back(i_tx_msg_id);
      last_id = i_tx_msg_id;
    end
  end
  task automatic send(input logic rep, input logic [7:0] code,
      input logic [47:0] src, input logic [127:0] id,
      input logic [15:0] tmo);
    @(posedge i_sys_clk);
    #1;
    o_rx_valid = 1'b1;
    o_rx_is_reply = rep;
    o_rx_code = code;
    o_rx_src = src;
    o_rx_msg_id = id;
    o_rx_srv_addr = SRV;
    o_rx_timeout_ms = tmo;
    o_rx_session = SESSION;
    @(posedge i_sys_clk);
    #1;
    o_rx_valid = 1'b0;
    // Released fields other than the timeout are inverted so a stale value never matches
    o_rx_is_reply = ~o_rx_is_reply;
    o_rx_code = ~o_rx_code;
    o_rx_src = ~o_rx_src;
    o_rx_msg_id = ~o_rx_msg_id;
    {o_rx_srv_addr, o_rx_session} = ~{o_rx_srv_addr, o_rx_session};
  endtask
  task automatic answer(input logic [7:0] code, input logic [15:0] tmo);
    send(1'b1, code, SRV, last_id, tmo);
  endtask
  // Never retries, so its retry time stays inside the client's wait
  task automatic order(input logic [7:0] code, input logic [95:0] sess,
      input logic [47:0] src, input logic [31:0] serial);
    send(1'b0, code, src, {sess, serial}, 16'h0000);
  endtask
endmodule

// [dv/net_boot_client_sequencer_bench.sv]
// Self-checking bench for the network boot client sequencer
module net_boot_client_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, kick, host, ready, done, tx_valid, tx_is_reply;
  logic order_valid, running, failed, cc_we, rx_valid, rx_is_reply;
  logic [7:0] rx_code, tx_code, tx_rc, order_code, status, cc_code;
  logic [7:0] result, last_ocode;
  logic [47:0] rx_src, rx_srv, tx_dest;
  logic [127:0] rx_id, tx_id;
  logic [15:0] rx_tmo;
  logic [95:0] rx_sess;
  int mismatches = 0;
  int num_checks = 0;
  int cc_pulses = 0;
  int orders = 0;
  int cyc = 0;
  localparam logic [7:0] DISC = net_boot_pkg::CODE_DISCOVERY;
  localparam logic [7:0] CLAIM = net_boot_pkg::CODE_CLAIM;
  localparam logic [47:0] BCAST = net_boot_pkg::BCAST_ADDR;
  net_boot_client_sequencer #(.CYC_PER_MS(1)) dut (
    .i_sys_clk(clk), .i_nrst(nrst), .i_boot_kickoff(kick),
    .i_host_started(host), .i_own_addr(48'h0200_0000_0B07),
    .i_rx_valid(rx_valid), .i_rx_is_reply(rx_is_reply),
    .i_rx_code(rx_code), .i_rx_src(rx_src), .i_rx_msg_id(rx_id),
    .i_rx_srv_addr(rx_srv), .i_rx_timeout_ms(rx_tmo),
    .i_rx_session(rx_sess), .i_tx_ready(ready), .i_order_done(done),
    .i_order_result(result), .o_tx_valid(tx_valid),
    .o_tx_is_reply(tx_is_reply), .o_tx_code(tx_code),
    .o_tx_reply_code(tx_rc), .o_tx_dest(tx_dest), .o_tx_msg_id(tx_id),
    .o_order_valid(order_valid), .o_order_code(order_code),
    .o_running(running), .o_failed(failed), .o_status_code(status),
    .o_host_cc_we(cc_we), .o_host_cc_code(cc_code)
  );
  boot_server_model srv (
    .i_sys_clk(clk), .i_tx_valid(tx_valid), .i_tx_ready(ready),
    .i_tx_code(tx_code), .i_tx_dest(tx_dest), .i_tx_msg_id(tx_id),
    .o_rx_valid(rx_valid), .o_rx_is_reply(rx_is_reply),
    .o_rx_code(rx_code), .o_rx_src(rx_src), .o_rx_msg_id(rx_id),
    .o_rx_srv_addr(rx_srv), .o_rx_timeout_ms(rx_tmo),
    .o_rx_session(rx_sess)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cc_we === 1'b1) cc_pulses++;
    if (order_valid === 1'b1) begin
      orders++;
      last_ocode = order_code;
    end
  end
  task automatic check(input string what, input logic [127:0] exp,
      input logic [127:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    step();
    nrst = 1'b0;
    repeat (12) step();
    nrst = 1'b1;
    srv.q_code.delete();
    srv.q_dest.delete();
    srv.q_id.delete();
    cc_pulses = 0;
    orders = 0;
  endtask
  task automatic pulse(ref logic sig);
    step();
    sig = 1'b1;
    step();
    sig = 1'b0;
  endtask
  task automatic take_tx(input logic [7:0] code, input logic [47:0] dest,
      output logic [127:0] id);
    int n;
    for (n = 0; n < 4000 && srv.q_code.size() == 0; n++) step();
    if (n == 4000) begin
      check("send wait", 1, 0);
      summarize();
    end
    check("send code", code, srv.q_code.pop_front());
    check("send dest", dest, srv.q_dest.pop_front());
    id = srv.q_id.pop_front();
  endtask
  task automatic wait_failed;
    int n;
    for (n = 0; n < 4000 && failed !== 1'b1; n++) step();
    if (n == 4000) begin
      check("fail wait", 1, 0);
      summarize();
    end
    // One more edge so the completion-code pulse is counted
    step();
  endtask
  task automatic normal_boot;
    logic [127:0] id;
    logic [7:0] codes[4] = '{net_boot_pkg::CODE_DOWNLOAD,
      net_boot_pkg::CODE_UPLOAD, net_boot_pkg::CODE_CONFIGURE,
      net_boot_pkg::CODE_RUN};
    do_reset();
    pulse(kick);
    take_tx(8'h04, net_boot_pkg::BCAST_ADDR, id);
    srv.order(codes[0], srv.SESSION, srv.SRV, 32'h0);
    srv.answer(net_boot_pkg::CODE_DISCOVERY, 16'h0000);
    take_tx(net_boot_pkg::CODE_CLAIM, srv.SRV, id);
    srv.answer(net_boot_pkg::CODE_DISCOVERY, 16'h0000);
    srv.order(codes[0], srv.SESSION, srv.SRV, 32'h0);
    srv.answer(net_boot_pkg::CODE_CLAIM, 16'h0000);
    srv.order(codes[0], ~srv.SESSION, srv.SRV, 32'h0);
    srv.order(codes[0], srv.SESSION, 48'h0200_0000_0C09, 32'h0);
    step();
    step();
    check("orders taken", 0, orders);
    check("stray send", 0, srv.q_code.size());
    foreach (codes[k]) begin
      srv.order(codes[k], srv.SESSION, srv.SRV, 32'hC0DE_0000 + k);
      step();
      step();
      check("order code", codes[k], last_ocode);
      result = 8'h10 + 8'(k);
      pulse(done);
      take_tx(codes[k], srv.SRV, id);
      check("reply id", {srv.SESSION, 32'hC0DE_0000 + k}, id);
      check("reply code", result, tx_rc);
      check("reply flag", 1, tx_is_reply);
    end
    check("running", 1, running);
    $display("normal boot done");
  endtask
  task automatic discovery_exhaust;
    logic [127:0] id;
    logic [127:0] ids[$];
    int t;
    do_reset();
    host = 1'b1;
    pulse(kick);
    repeat (16) begin
      take_tx(DISC, BCAST, id);
      check("fresh id", 0, id inside {ids});
      if (ids.size() > 0)
        check("retry gap", 1, (cyc - t) inside {[2999:3008]});
      t = cyc;
      ids.push_back(id);
    end
    wait_failed();
    check("failed", 1, failed);
    check("extra send", 0, srv.q_code.size());
    check("host writes", 1, cc_pulses);
    check("host code", net_boot_pkg::ERR_DISCOVERY, cc_code);
    host = 1'b0;
    pulse(kick);
    step();
    check("status", net_boot_pkg::ERR_DISCOVERY, status);
    $display("discovery exhaustion done");
  endtask
  task automatic claim_exhaust;
    logic [127:0] id;
    do_reset();
    pulse(kick);
    take_tx(DISC, BCAST, id);
    repeat (15) begin
      srv.answer(DISC, 16'h0005);
      repeat (16) take_tx(CLAIM, srv.SRV, id);
      take_tx(DISC, BCAST, id);
      check("not failed", 0, failed);
    end
    srv.answer(DISC, 16'h0005);
    repeat (16) take_tx(CLAIM, srv.SRV, id);
    wait_failed();
    check("claim abort", net_boot_pkg::ERR_CLAIM, status);
    check("extra send", 0, srv.q_code.size());
    check("no host write", 0, cc_pulses);
    $display("claim exhaustion done");
  endtask
  task automatic order_timeout;
    logic [127:0] id;
    do_reset();
    pulse(kick);
    take_tx(DISC, BCAST, id);
    repeat (15) begin
      srv.answer(DISC, 16'h0005);
      take_tx(CLAIM, srv.SRV, id);
      srv.answer(CLAIM, 16'h0005);
      take_tx(DISC, BCAST, id);
      check("no run", 0, running);
    end
    srv.answer(DISC, 16'h0005);
    take_tx(CLAIM, srv.SRV, id);
    srv.answer(CLAIM, 16'h0005);
    wait_failed();
    check("order abort", net_boot_pkg::ERR_ORDER, status);
    check("extra send", 0, srv.q_code.size());
    $display("order timeout done");
  endtask
  initial begin
    {nrst, kick, host, done} = '0;
    ready = 1'b1;
    result = 8'h00;
    last_ocode = 8'h00;
    normal_boot();
    discovery_exhaust();
    claim_exhaust();
    order_timeout();
    summarize();
  end
endmodule
